// *** dual_timer_pkg.sv ***
package dual_timer_pkg;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_AUX_CTRL   = 8'h00; // Auxiliary timer control
	localparam logic [7:0] OFS_CORE_CTRL  = 8'h04; // Core timer control
	localparam logic [7:0] OFS_AUX_TIMER  = 8'h08; // Auxiliary timer count
	localparam logic [7:0] OFS_CORE_TIMER = 8'h0C; // Core timer count
	localparam logic [7:0] OFS_CAPTURE_RELOAD_REG     = 8'h10; // Capture/reload value
	localparam logic [7:0] OFS_STATUS     = 8'h14; // Sticky events, read only
	localparam logic [7:0] OFS_IRQ_EN     = 8'h18; // Interrupt enables
	localparam logic [7:0] OFS_IRQ_CLR    = 8'h1C; // Write one to clear, write only
	localparam logic [7:0] OFS_LATCH      = 8'h20; // Toggle latch state, read only

	// ------------------------------------------------------------
	// Widths, reset values, event bit positions
	// ------------------------------------------------------------
	localparam int          TMR_W        = 16;       // Timer and capture width
	localparam int          EV_W         = 4;        // Number of event bits
	localparam int          PRE_W        = 8;        // Prescaler divider width
	localparam int          EDGE_N       = 6;        // Number of edge detectors
	localparam logic [15:0] TMR_RST      = 16'h0000; // Timer reset value
	localparam logic [15:0] TMR_MAX      = 16'hFFFF; // Top of count
	localparam int          EV_CORE_OVF  = 0;        // Core overflow
	localparam int          EV_CORE_UNF  = 1;        // Core underflow
	localparam int          EV_CAPTURE   = 2;        // Capture taken
	localparam int          EV_AUX_WRAP  = 3;        // Auxiliary wrap
	localparam int          ED_CAPTURE_INPUT_PIN     = 0;        // Capture pin detector
	localparam int          ED_NB_COUNT  = 1;        // Neighbour count input
	localparam int          ED_NB_DIR    = 2;        // Neighbour direction input
	localparam int          ED_AUX_CNT   = 3;        // Aux external count pin
	localparam int          ED_CORE_CNT  = 4;        // Core external count pin
	localparam int          ED_LATCH     = 5;        // Toggle latch as aux clock

	// ------------------------------------------------------------
	// Enumerations
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		EDGE_NONE = 2'h0,
		EDGE_RISE = 2'h1,
		EDGE_FALL = 2'h2,
		EDGE_BOTH = 2'h3
	} edge_mode_t;

	typedef enum logic [1:0] {
		AUX_SRC_PRESC = 2'h0,
		AUX_SRC_PIN   = 2'h1,
		AUX_SRC_LATCH = 2'h2,
		AUX_SRC_OFF   = 2'h3
	} aux_src_t;

	typedef enum logic [1:0] {
		CAP_SRC_PIN   = 2'h0,
		CAP_SRC_COUNT = 2'h1,
		CAP_SRC_DIR   = 2'h2,
		CAP_SRC_BOTH  = 2'h3
	} cap_src_t;

	// ------------------------------------------------------------
	// Control register layouts (LSB last)
	// ------------------------------------------------------------
	typedef struct packed {
		cap_src_t   cap_src;  // [12:11]
		edge_mode_t cap_edge; // [10:9]
		logic       clr_cap;  // [8]
		logic       ext_dir;  // [7]
		logic       down;     // [6]
		logic       run;      // [5]
		aux_src_t   src;      // [4:3]
		logic [2:0] pre;      // [2:0]
	} aux_ctrl_t;

	typedef struct packed {
		logic       out_en;    // [9]
		logic       reload_en; // [8]
		logic       ext_dir;   // [7]
		logic       down;      // [6]
		logic       run;       // [5]
		logic       src_ext;   // [4]
		logic       rsvd;      // [3]
		logic [2:0] pre;       // [2:0]
	} core_ctrl_t;

	localparam int AUX_CTRL_W  = $bits(aux_ctrl_t);
	localparam int CORE_CTRL_W = $bits(core_ctrl_t);

	// Whole state of the top module
	typedef struct packed {
		aux_ctrl_t         aux_ctrl;
		core_ctrl_t        core_ctrl;
		logic [15:0]       aux;
		logic [15:0]       core;
		logic [15:0]       capture_reload_reg;
		logic              latch;
		logic              latch_pin;
		logic              count_pulse;
		logic [EV_W-1:0]   status;
		logic [EV_W-1:0]   irq_en;
		logic              irq;
		logic [PRE_W-1:0]  prediv;
		logic              pready;
		logic              pslverr;
		logic [31:0]       prdata;
	} top_state_t;

endpackage : dual_timer_pkg

// *** dual_timer_unit.sv ***
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps

module dual_timer_unit
(
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        capture_input_pin,
	input  wire logic        neighbour_count_input,
	input  wire logic        neighbour_direction_input,
	input  wire logic        aux_count_input,
	input  wire logic        core_count_input,
	input  wire logic        aux_direction_input,
	input  wire logic        core_direction_input,
	output logic             toggle_latch_pin,
	output logic             core_count_pulse,
	output logic             irq
);

	// ------------------------------------------------------------
	// State and decode
	// ------------------------------------------------------------
	dual_timer_pkg::top_state_t s;      // Registered state
	dual_timer_pkg::top_state_t next_s; // Next state

	logic [dual_timer_pkg::EDGE_N-1:0]  ed_sig;  // Detector inputs
	logic [dual_timer_pkg::EDGE_N-1:0]  ed_hit;  // Detector hits
	dual_timer_pkg::edge_mode_t         ed_mode [dual_timer_pkg::EDGE_N]; // Per detector mode
	logic                               acc;     // Access phase, answer not yet given
	logic                               wr;      // Write takes effect this edge
	logic                               aux_tick;   // Aux counting step
	logic                               core_tick;  // Core counting step
	logic                               aux_down;   // Aux effective direction
	logic                               core_down;  // Core effective direction
	logic                               core_wrap;  // Core overflow or underflow
	logic                               core_ovf;   // Core overflow
	logic                               core_unf;   // Core underflow
	logic                               aux_wrap;   // Aux overflow or underflow
	logic                               cap_hit;    // Capture trigger
	logic                               tick_fast;  // Fastest prescaler step
	logic [dual_timer_pkg::EV_W-1:0]    ev;         // Events this cycle
	logic [31:0]                        rd_val;     // Read mux
	logic                               rd_ok;      // Address is mapped

	// The answer comes one cycle into the access phase
	assign acc = psel & penable & ~s.pready;
	assign wr  = psel & penable & pwrite & s.pready;

	// ------------------------------------------------------------
	// Edge detectors
	// ------------------------------------------------------------
	assign ed_sig  = {s.latch, core_count_input, aux_count_input,
			neighbour_direction_input, neighbour_count_input, capture_input_pin};
	assign ed_mode[dual_timer_pkg::ED_CAPTURE_INPUT_PIN]    = s.aux_ctrl.cap_edge;
	assign ed_mode[dual_timer_pkg::ED_NB_COUNT] = s.aux_ctrl.cap_edge;
	assign ed_mode[dual_timer_pkg::ED_NB_DIR]   = s.aux_ctrl.cap_edge;
	assign ed_mode[dual_timer_pkg::ED_AUX_CNT]  = dual_timer_pkg::EDGE_RISE;
	assign ed_mode[dual_timer_pkg::ED_CORE_CNT] = dual_timer_pkg::EDGE_RISE;
	// Both latch edges, so the aux timer counts every core wrap
	assign ed_mode[dual_timer_pkg::ED_LATCH]    = dual_timer_pkg::EDGE_BOTH;

	genvar gi;
	generate
		for (gi = 0; gi < dual_timer_pkg::EDGE_N; gi++)
		begin : g_edge
			edge_detect u_edge
			(
				.clock   (clock),
				.sys_rst (sys_rst),
				.sig     (ed_sig[gi]),
				.mode    (ed_mode[gi]),
				.hit     (ed_hit[gi])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Prescaler and clock selection
	// ------------------------------------------------------------
	// Step for setting k is every 2^(k+1) clocks
	function automatic logic presc_tick(input logic [7:0] div, input logic [2:0] sel);
		logic [7:0] mask;
		mask = 8'hFF >> (3'h7 - sel);
		return (div & mask) == mask;
	endfunction : presc_tick

	assign tick_fast = presc_tick(s.prediv, 3'h0);

	// Clock source per timer
	always_comb
	begin
		case (s.aux_ctrl.src)
			dual_timer_pkg::AUX_SRC_PRESC: aux_tick = presc_tick(s.prediv, s.aux_ctrl.pre);
			dual_timer_pkg::AUX_SRC_PIN:   aux_tick = ed_hit[dual_timer_pkg::ED_AUX_CNT];
			dual_timer_pkg::AUX_SRC_LATCH: aux_tick = ed_hit[dual_timer_pkg::ED_LATCH];
			default:                       aux_tick = 1'b0;
		endcase
		aux_tick  = aux_tick & s.aux_ctrl.run;
		core_tick = s.core_ctrl.run & (s.core_ctrl.src_ext ?
				ed_hit[dual_timer_pkg::ED_CORE_CNT] : presc_tick(s.prediv, s.core_ctrl.pre));
	end

	// Pin level overrides the software direction when enabled
	assign aux_down  = s.aux_ctrl.ext_dir ? aux_direction_input : s.aux_ctrl.down;
	assign core_down = s.core_ctrl.ext_dir ? core_direction_input : s.core_ctrl.down;

	// ------------------------------------------------------------
	// Wrap and capture events
	// ------------------------------------------------------------
	assign core_ovf  = core_tick & ~core_down & (s.core == dual_timer_pkg::TMR_MAX);
	assign core_unf  = core_tick & core_down & (s.core == dual_timer_pkg::TMR_RST);
	assign core_wrap = core_ovf | core_unf;
	assign aux_wrap  = aux_tick & (aux_down ? (s.aux == dual_timer_pkg::TMR_RST)
			: (s.aux == dual_timer_pkg::TMR_MAX));

	// Capture source select
	always_comb
	begin
		case (s.aux_ctrl.cap_src)
			dual_timer_pkg::CAP_SRC_PIN:   cap_hit = ed_hit[dual_timer_pkg::ED_CAPTURE_INPUT_PIN];
			dual_timer_pkg::CAP_SRC_COUNT: cap_hit = ed_hit[dual_timer_pkg::ED_NB_COUNT];
			dual_timer_pkg::CAP_SRC_DIR:   cap_hit = ed_hit[dual_timer_pkg::ED_NB_DIR];
			default:                       cap_hit = ed_hit[dual_timer_pkg::ED_NB_COUNT]
					| ed_hit[dual_timer_pkg::ED_NB_DIR];
		endcase
	end

	always_comb
	begin
		ev = '0;
		ev[dual_timer_pkg::EV_CORE_OVF] = core_ovf;
		ev[dual_timer_pkg::EV_CORE_UNF] = core_unf;
		ev[dual_timer_pkg::EV_CAPTURE]  = cap_hit;
		ev[dual_timer_pkg::EV_AUX_WRAP] = aux_wrap;
	end

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	always_comb
	begin
		rd_val = '0;
		rd_ok  = 1'b1;
		case (paddr)
			dual_timer_pkg::OFS_AUX_CTRL:   rd_val = 32'(s.aux_ctrl);
			dual_timer_pkg::OFS_CORE_CTRL:  rd_val = 32'(s.core_ctrl);
			dual_timer_pkg::OFS_AUX_TIMER:  rd_val = 32'(s.aux);
			dual_timer_pkg::OFS_CORE_TIMER: rd_val = 32'(s.core);
			dual_timer_pkg::OFS_CAPTURE_RELOAD_REG:     rd_val = 32'(s.capture_reload_reg);
			dual_timer_pkg::OFS_STATUS:     rd_val = 32'(s.status);
			dual_timer_pkg::OFS_IRQ_EN:     rd_val = 32'(s.irq_en);
			dual_timer_pkg::OFS_IRQ_CLR:    rd_val = '0; // Write only
			dual_timer_pkg::OFS_LATCH:      rd_val = 32'(s.latch);
			default:                        rd_ok  = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		next_s        = s;
		next_s.prediv = s.prediv + 8'h01;

		// Bus answer, one wait cycle
		next_s.pready  = acc;
		next_s.pslverr = acc & ~rd_ok;
		if (acc && !pwrite)
			next_s.prdata = rd_val;

		// Core timer counts; wraps are modulo 16 bits unless reload_en loads capture_reload_reg
		if (core_tick)
			next_s.core = core_down ? s.core - 16'h0001 : s.core + 16'h0001;
		if (core_wrap)
		begin
			next_s.latch = ~s.latch;
			if (s.core_ctrl.reload_en)
				next_s.core = s.capture_reload_reg;
		end
		next_s.count_pulse = core_wrap;

		// Aux timer counts
		if (aux_tick)
			next_s.aux = aux_down ? s.aux - 16'h0001 : s.aux + 16'h0001;

		// Software writes, taken at the edge that completes the access
		if (wr)
		begin
			case (paddr)
				dual_timer_pkg::OFS_AUX_CTRL:
					next_s.aux_ctrl = dual_timer_pkg::aux_ctrl_t'(pwdata[dual_timer_pkg::AUX_CTRL_W-1:0]);
				dual_timer_pkg::OFS_CORE_CTRL:
					next_s.core_ctrl = dual_timer_pkg::core_ctrl_t'(pwdata[dual_timer_pkg::CORE_CTRL_W-1:0]);
				dual_timer_pkg::OFS_AUX_TIMER:  next_s.aux    = pwdata[15:0];
				dual_timer_pkg::OFS_CORE_TIMER: next_s.core   = pwdata[15:0];
				dual_timer_pkg::OFS_CAPTURE_RELOAD_REG:     next_s.capture_reload_reg = pwdata[15:0];
				dual_timer_pkg::OFS_IRQ_EN:     next_s.irq_en = pwdata[dual_timer_pkg::EV_W-1:0];
				dual_timer_pkg::OFS_IRQ_CLR:
					next_s.status = s.status & ~pwdata[dual_timer_pkg::EV_W-1:0];
				default:                        next_s.status = next_s.status;
			endcase
		end

		// Capture beats a software write to the capture register
		if (cap_hit)
		begin
			next_s.capture_reload_reg = s.aux;
			if (s.aux_ctrl.clr_cap)
				next_s.aux = dual_timer_pkg::TMR_RST;
		end

		// Events set sticky bits; set wins over clear
		next_s.status    = next_s.status | ev;
		next_s.irq       = |(next_s.status & next_s.irq_en);
		next_s.latch_pin = next_s.latch & next_s.core_ctrl.out_en;
	end

	// Register the copy
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			s <= '0;
		else
			s <= next_s;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign prdata           = s.prdata;
	assign pready           = s.pready;
	assign pslverr          = s.pslverr;
	assign toggle_latch_pin = s.latch_pin;
	assign core_count_pulse = s.count_pulse;
	assign irq              = s.irq;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	sequence s_wrap_out;
		core_wrap && s.core_ctrl.out_en ##1 s.core_ctrl.out_en;
	endsequence

	sequence s_capture_clear;
		cap_hit && s.aux_ctrl.clr_cap;
	endsequence

	AST_PRESC_TWO: assert property (tick_fast |=> !tick_fast ##1 tick_fast)
		else $error("fastest prescaler step is not two clocks");

	AST_EXT_HOLD: assert property (s.core_ctrl.run && s.core_ctrl.src_ext
			&& !ed_hit[dual_timer_pkg::ED_CORE_CNT] && !wr |=> $stable(s.core))
		else $error("core timer moved without an external edge");

	AST_EXT_DIR: assert property (s.core_ctrl.ext_dir && core_direction_input && core_tick
			&& s.core != dual_timer_pkg::TMR_RST && !wr |=> s.core == $past(s.core) - 16'h0001)
		else $error("external direction pin did not count down");

	AST_TOGGLE: assert property (core_wrap |=> s.latch != $past(s.latch))
		else $error("toggle latch did not flip on core wrap");

	AST_LATCH_PIN: assert property (s_wrap_out |-> toggle_latch_pin == s.latch)
		else $error("latch pin does not follow the latch");

	AST_RELOAD: assert property (core_wrap && s.core_ctrl.reload_en && !wr
			|=> s.core == $past(s.capture_reload_reg))
		else $error("core timer not reloaded on wrap");

	AST_PULSE: assert property (core_wrap |=> core_count_pulse ##1 (core_count_pulse == $past(core_wrap)))
		else $error("count pulse does not follow core wrap");

	AST_CAPTURE: assert property (cap_hit |=> s.capture_reload_reg == $past(s.aux))
		else $error("capture did not copy the aux timer");

	AST_CLEAR: assert property (s_capture_clear |=> s.aux == dual_timer_pkg::TMR_RST)
		else $error("aux timer not cleared after capture");

	AST_NEIGHBOUR: assert property (s.aux_ctrl.cap_src == dual_timer_pkg::CAP_SRC_BOTH
			&& (ed_hit[dual_timer_pkg::ED_NB_COUNT] || ed_hit[dual_timer_pkg::ED_NB_DIR])
			|=> s.status[dual_timer_pkg::EV_CAPTURE])
		else $error("neighbour edge did not capture");

	AST_NO_EDGE: assert property (s.aux_ctrl.cap_edge == dual_timer_pkg::EDGE_NONE |-> !cap_hit)
		else $error("capture without a selected edge");

	AST_WRAP16: assert property (aux_tick && !aux_down && s.aux == dual_timer_pkg::TMR_MAX
			&& !cap_hit && !wr |=> s.aux == dual_timer_pkg::TMR_RST)
		else $error("aux timer did not wrap to zero");

endmodule : dual_timer_unit

// *** edge_detect.sv ***
`timescale 1ns/1ps

// Selectable edge detector; hit is combinational from a held copy
module edge_detect
(
	input  wire logic                       clock,
	input  wire logic                       sys_rst,
	input  wire logic                       sig,
	input  wire dual_timer_pkg::edge_mode_t mode,
	output logic                            hit
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic prev; // Level seen last cycle
	} edge_state_t;

	edge_state_t s;      // Registered state
	edge_state_t next_s; // Next state

	// Remember the last level
	always_comb
	begin
		next_s      = s;
		next_s.prev = sig;
	end

	// Register the copy
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			s <= '0;
		else
			s <= next_s;
	end

	// No edge selected means never a hit
	assign hit = (sig & ~s.prev & mode[0]) | (~sig & s.prev & mode[1]);

endmodule : edge_detect

// *** ext_pins_model.sv ***
`timescale 1ns/1ps

// ------------------------------------------------------------
// Far side: count, direction, capture and neighbour pins
// ------------------------------------------------------------
// Bit map: 0 capture, 1 nb count, 2 nb dir, 3 aux cnt,
// 4 core cnt, 5 aux dir, 6 core dir
module ext_pins_model
(
	input  wire logic       clock,
	output logic      [6:0] pins
);
	initial pins = 7'h00; // All pins idle low

	// Level change just after a rising edge
	task automatic set_pin(input int i, input logic v);
		@(posedge clock);
		pins[i] <= v;
	endtask : set_pin

	// Two cycles high, two low, so the edge detector sees both
	task automatic pulse(input int i);
		set_pin(i, 1'b1);
		repeat (2) @(posedge clock);
		pins[i] <= 1'b0;
		repeat (2) @(posedge clock);
	endtask : pulse
endmodule : ext_pins_model

// *** tb.sv ***
`timescale 1ns/1ps

module tb;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic        clock;           // 50 MHz
	logic        sys_rst;         // Held at start
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [6:0]  pins;            // From far-side model
	logic        toggle_latch_pin;
	logic        core_count_pulse;
	logic        irq;
	int          fails      = 0;  // Mismatches
	int          n_compared = 0;  // Comparisons
	int          pulses     = 0;  // Core wrap pulses seen
	logic [31:0] q;
	logic        e;

	typedef struct packed {
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] q;
		logic        e;
	} row_t;

	// Write, then read back: masks, read-only places, unmapped
	localparam row_t rows [6] = '{
		'{dual_timer_pkg::OFS_CAPTURE_RELOAD_REG, 32'hFFFF1234, 32'h00001234, 1'b0},
		'{dual_timer_pkg::OFS_AUX_TIMER, 32'h0000BEEF, 32'h0000BEEF, 1'b0},
		'{dual_timer_pkg::OFS_CORE_TIMER, 32'h0001FFFF, 32'h0000FFFF, 1'b0},
		'{dual_timer_pkg::OFS_STATUS, 32'h0000000F, 32'h00000000, 1'b0},
		'{dual_timer_pkg::OFS_LATCH, 32'h00000001, 32'h00000000, 1'b0},
		'{8'h24, 32'h12345678, 32'h00000000, 1'b1}};

	always #10 clock = ~clock;

	// Count exported wrap pulses as they stand
	always @(posedge clock)
	begin
		if (core_count_pulse === 1'b1)
			pulses <= pulses + 1;
	end

	dual_timer_unit dut (
		.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .capture_input_pin(pins[0]),
		.neighbour_count_input(pins[1]), .neighbour_direction_input(pins[2]),
		.aux_count_input(pins[3]), .core_count_input(pins[4]),
		.aux_direction_input(pins[5]), .core_direction_input(pins[6]),
		.toggle_latch_pin(toggle_latch_pin), .core_count_pulse(core_count_pulse),
		.irq(irq));

	ext_pins_model far (.clock(clock), .pins(pins));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One APB transfer; pready sampled at the rising edge, then released
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clock);
		penable <= 1'b1;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			fails++;
			give_verdict();
		end
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// Let the completing edge settle before outputs are looked at
		@(negedge clock);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(q, exp);
	endtask : rdc

	// Single place where the run ends
	task automatic give_verdict;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : give_verdict

	// Watchdog: the whole sequence needs under a thousand cycles
	initial
	begin
		repeat (20000) @(posedge clock);
		fails++;
		give_verdict();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		logic [15:0] v;
		clock   = 1'b0;
		sys_rst = 1'b1;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
		repeat (16) @(posedge clock);
		sys_rst <= 1'b0;
		for (int i = 0; i < 9; i++)
		begin
			if (i != 7)
				rdc(8'(i * 4), 32'h0);
		end
		check({31'h0, toggle_latch_pin | irq}, 32'h0);
		$display("test reset done");
		// Table of ordinary accesses
		for (int i = 0; i < 6; i++)
		begin
			wr(rows[i].a, rows[i].d);
			check({31'h0, e}, {31'h0, rows[i].e});
			rdc(rows[i].a, rows[i].q);
		end
		$display("test registers done");
		// Core overflow with reload, latch to pin, irq
		wr(dual_timer_pkg::OFS_CORE_TIMER, 32'h0000FFFF);
		wr(dual_timer_pkg::OFS_IRQ_EN, 32'h1);
		wr(dual_timer_pkg::OFS_CORE_CTRL, 32'h330);
		far.pulse(4);
		rdc(dual_timer_pkg::OFS_CORE_TIMER, 32'h1234);
		rdc(dual_timer_pkg::OFS_LATCH, 32'h1);
		check({31'h0, toggle_latch_pin}, 32'h1);
		check(pulses, 32'h1);
		rdc(dual_timer_pkg::OFS_STATUS, 32'h1);
		check({31'h0, irq}, 32'h1);
		// Underflow without reload, counting down
		wr(dual_timer_pkg::OFS_CORE_CTRL, 32'h270);
		wr(dual_timer_pkg::OFS_CORE_TIMER, 32'h0);
		far.pulse(4);
		rdc(dual_timer_pkg::OFS_CORE_TIMER, 32'hFFFF);
		rdc(dual_timer_pkg::OFS_STATUS, 32'h3);
		rdc(dual_timer_pkg::OFS_LATCH, 32'h0);
		check(pulses, 32'h2);
		// Direction from the pin level
		wr(dual_timer_pkg::OFS_CORE_CTRL, 32'h2B0);
		far.set_pin(6, 1'b1);
		far.pulse(4);
		rdc(dual_timer_pkg::OFS_CORE_TIMER, 32'hFFFE);
		far.set_pin(6, 1'b0);
		far.pulse(4);
		rdc(dual_timer_pkg::OFS_CORE_TIMER, 32'hFFFF);
		// Mask then clear the interrupt
		wr(dual_timer_pkg::OFS_IRQ_EN, 32'h0);
		check({31'h0, irq}, 32'h0);
		wr(dual_timer_pkg::OFS_IRQ_CLR, 32'hF);
		rdc(dual_timer_pkg::OFS_STATUS, 32'h0);
		$display("test core done");
		// Aux clocked by the latch: two core wraps, two counts
		wr(dual_timer_pkg::OFS_AUX_TIMER, 32'h0);
		wr(dual_timer_pkg::OFS_AUX_CTRL, 32'h30);
		far.pulse(4);
		// Core has wrapped to zero; put it back at the top for a second wrap
		wr(dual_timer_pkg::OFS_CORE_TIMER, 32'h0000FFFF);
		far.pulse(4);
		rdc(dual_timer_pkg::OFS_AUX_TIMER, 32'h2);
		// External clock, wrap, capture with clear
		wr(dual_timer_pkg::OFS_AUX_CTRL, 32'h328);
		wr(dual_timer_pkg::OFS_AUX_TIMER, 32'hFFFF);
		far.pulse(3);
		rdc(dual_timer_pkg::OFS_AUX_TIMER, 32'h0);
		wr(dual_timer_pkg::OFS_AUX_TIMER, 32'h5);
		repeat (3) far.pulse(3);
		rdc(dual_timer_pkg::OFS_AUX_TIMER, 32'h8);
		far.set_pin(0, 1'b1);
		rdc(dual_timer_pkg::OFS_CAPTURE_RELOAD_REG, 32'h8);
		rdc(dual_timer_pkg::OFS_AUX_TIMER, 32'h0);
		far.set_pin(0, 1'b0);
		rdc(dual_timer_pkg::OFS_CAPTURE_RELOAD_REG, 32'h8);
		wr(dual_timer_pkg::OFS_AUX_CTRL, 32'hA8);
		far.set_pin(5, 1'b1);
		far.pulse(3);
		rdc(dual_timer_pkg::OFS_AUX_TIMER, 32'hFFFF);
		far.set_pin(5, 1'b0);
		far.pulse(3);
		rdc(dual_timer_pkg::OFS_AUX_TIMER, 32'h0);
		$display("test capture done");
		// Every edge mode against every trigger source setting; only the neighbour pins are driven, never the capture pin
		for (int m = 0; m < 4; m++)
		begin
			for (int s = 0; s < 4; s++)
			begin
				v = 16'(m * 4 + s + 1);
				wr(dual_timer_pkg::OFS_AUX_CTRL, 32'((s << 11) | (m << 9) | 8'h18));
				wr(dual_timer_pkg::OFS_AUX_TIMER, {16'h0, v});
				wr(dual_timer_pkg::OFS_CAPTURE_RELOAD_REG, 32'h0);
				far.set_pin((s == 2) ? 2 : 1, 1'b1);
				rdc(dual_timer_pkg::OFS_CAPTURE_RELOAD_REG, (s != 0 && m[0]) ? v : 32'h0);
				wr(dual_timer_pkg::OFS_CAPTURE_RELOAD_REG, 32'h0);
				far.set_pin((s == 2) ? 2 : 1, 1'b0);
				rdc(dual_timer_pkg::OFS_CAPTURE_RELOAD_REG, (s != 0 && m[1]) ? v : 32'h0);
			end
		end
		$display("test edges done");
		// Fastest prescaler: one step per two clocks over ~104 clocks
		wr(dual_timer_pkg::OFS_AUX_TIMER, 32'h0);
		wr(dual_timer_pkg::OFS_AUX_CTRL, 32'h20);
		repeat (100) @(posedge clock);
		wr(dual_timer_pkg::OFS_AUX_CTRL, 32'h0);
		apb(1'b0, dual_timer_pkg::OFS_AUX_TIMER, 32'h0);
		check({31'h0, q >= 32'd50 && q <= 32'd56}, 32'h1);
		// Second reset in mid-run
		@(posedge clock);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		rdc(dual_timer_pkg::OFS_CAPTURE_RELOAD_REG, 32'h0);
		check({31'h0, toggle_latch_pin}, 32'h0);
		$display("test prescaler and reset done");
		give_verdict();
	end
endmodule : tb
